// ===== common/flash_ctrl_pkg.sv
// Constants, command codes and timing for the flash operation controller
package flash_ctrl_pkg;

  // Command codes
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] sector_erase_cmd = 8'h20;
  localparam logic [7:0] block32_erase_cmd = 8'h52;
  localparam logic [7:0] block64_erase_cmd = 8'hd8;
  localparam logic [7:0] suspend_cmd_a = 8'h75;
  localparam logic [7:0] suspend_cmd_b = 8'hb0;
  localparam logic [7:0] resume_cmd_a = 8'h7a;
  localparam logic [7:0] resume_cmd_b = 8'h30;
  localparam logic [7:0] reset_arm_cmd = 8'h66;
  localparam logic [7:0] soft_reset_cmd = 8'h99;
  localparam logic [7:0] idle_cmd = 8'h00;
  localparam logic [7:0] param_table_read_cmd = 8'h5a;

  // Frame layout, in bytes, and the last bit index of a byte
  localparam logic [3:0] opcode_bytes = 4'h1;
  localparam logic [3:0] addr_frame_bytes = 4'h4;
  localparam logic [3:0] last_addr_byte = 4'h3;
  localparam logic [3:0] table_hdr_bytes = 4'h5;
  localparam logic [3:0] byte_cnt_max = 4'hf;
  localparam logic [2:0] last_bit = 3'h7;

  // Suspend flag positions in the security status byte
  localparam int prog_susp_bit = 2;
  localparam int erase_susp_bit = 3;

  // Erase region masks
  localparam logic [23:0] sector_mask = 24'hfff000;
  localparam logic [23:0] block32_mask = 24'hff8000;
  localparam logic [23:0] block64_mask = 24'hff0000;

  // Timing at the 100 MHz core clock
  localparam int clk_mhz = 100;
  localparam int reset_pulse_min_us = 10;
  localparam int reset_recovery_decode_us = 30;
  localparam int reset_recovery_program_us = 80;
  localparam int reset_recovery_erase_ms = 12;
  localparam int por_recovery_us = 35;
  localparam int reset_pulse_min_cyc = reset_pulse_min_us * clk_mhz;
  localparam int recovery_decode_cyc = reset_recovery_decode_us * clk_mhz;
  localparam int recovery_program_cyc = reset_recovery_program_us * clk_mhz;
  localparam int recovery_erase_cyc = reset_recovery_erase_ms * 1000 * clk_mhz;
  localparam int por_recovery_cyc = por_recovery_us * clk_mhz;
  localparam int program_time_cyc = 2000;
  localparam int erase_time_cyc = 4000;
  localparam int suspend_latency_cyc = 200;
  localparam int cnt_w = 24;
  localparam int pin_cnt_w = 11;

  typedef enum logic [1:0] {op_none, op_program, op_erase} op_t;

endpackage

// ===== logic/flash_suspend_resume_reset_ctrl.sv
// Suspend, resume, reset and parameter table control of a serial flash
// How it works
// - During erase suspend, program anywhere except the suspended erase region.
// - Program started in erase suspend cannot suspend; must finish before resume.
// - That program holds write latch and busy flag at 1, clears both at end.
// - Resume restarts the held program or erase until done or suspended again.
// - Resume sets write latch and busy flag, clears the matching suspend flag.
// - Resume ignored in continuous-read enhanced mode.
// - Idle command only cancels a pending reset arm.
// - Soft reset acts only directly after the reset arm command.
// - Software reset restores standby and all volatile defaults.
// - Software reset aborts any running program or erase.
// - Not ready for 30 us, 80 us program, or 12 ms erase after reset.
// - Reset pin low for 10 us resets to standby and defaults.
// - While reset pin low, output floats; operations end once it stays low 10 us.
// - Table read: opcode, 3 address bytes, dummy byte, then streamed data.
// - Power-up enters standby with the write latch cleared.
// - Below supply threshold logic held in reset, no command answered.
// - Program suspend flag at bit 2, erase suspend flag at bit 3.
// - After suspend latency clear write latch, set suspend flag.
`timescale 1ns/10ps
module flash_suspend_resume_reset_ctrl #(
  parameter int PROGRAM_CYC = flash_ctrl_pkg::program_time_cyc,
  parameter int ERASE_CYC = flash_ctrl_pkg::erase_time_cyc,
  parameter int SUSPEND_LAT_CYC = flash_ctrl_pkg::suspend_latency_cyc,
  parameter int RECOVER_PROGRAM_CYC = flash_ctrl_pkg::recovery_program_cyc,
  parameter int RECOVER_ERASE_CYC = flash_ctrl_pkg::recovery_erase_cyc
) (
  // Core clock and supply-threshold reset
  input wire logic clk,
  input wire logic srst,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Hardware reset pin
  input wire logic reset_pin_n,
  // Continuous-read enhanced mode, from the read logic
  input wire logic enhance_mode,
  // Status
  output logic write_enable_latch,
  output logic op_in_progress_flag,
  output logic program_suspended_flag,
  output logic erase_suspended_flag,
  output logic [7:0] security_status,
  output logic device_ready,
  output logic op_aborted
);
  import flash_ctrl_pkg::*;

  logic cs_s;
  logic cs_prev;
  logic pin_s;
  logic frame_rst;
  logic [7:0] f_opcode;
  logic [23:0] f_addr;
  logic [3:0] f_bytes;
  logic f_whole;
  logic [pin_cnt_w-1:0] pin_cnt;
  logic [cnt_w-1:0] rec_cnt;
  logic [cnt_w-1:0] run_cnt;
  logic [cnt_w-1:0] held_cnt;
  logic [cnt_w-1:0] lat_cnt;
  logic [23:0] region;
  logic [23:0] region_msk;
  logic armed;
  logic suspending;
  logic link_ok;
  op_t run_kind;
  op_t held_kind;
  logic frame_end;
  logic accept;
  logic one_byte;
  logic pin_hold;
  logic soft_reset;
  logic reset_go;
  logic running;
  logic nested;
  logic write_enable_cmd_ok;
  logic pp_ok;
  logic erase_ok;
  logic susp_req;
  logic susp_done;
  logic resume_ok;
  logic op_done;
  logic [7:0] next_security;

  function automatic logic is_cmd(input logic [7:0] op, input logic [7:0] code);
    is_cmd = (op == code);
  endfunction

  function automatic logic [23:0] erase_mask(input logic [7:0] op);
    if (op == sector_erase_cmd) begin
      erase_mask = sector_mask;
    end else if (op == block32_erase_cmd) begin
      erase_mask = block32_mask;
    end else begin
      erase_mask = block64_mask;
    end
  endfunction

  function automatic logic [cnt_w-1:0] recovery_cycles(input op_t kind);
    case (kind)
      op_program: recovery_cycles = cnt_w'(RECOVER_PROGRAM_CYC);
      op_erase: recovery_cycles = cnt_w'(RECOVER_ERASE_CYC);
      default: recovery_cycles = cnt_w'(recovery_decode_cyc);
    endcase
  endfunction

  // Frame logic is also cleared straight from the reset pin, so the output floats at once
  assign frame_rst = cs_n | ~reset_pin_n;

  level_sync u_cs (
    .clk(clk),
    .d(cs_n),
    .q(cs_s)
  );

  level_sync u_pin (
    .clk(clk),
    .d(reset_pin_n),
    .q(pin_s)
  );

  param_table_link u_link (
    .sclk(sclk),
    .frame_rst(frame_rst),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .table_ok(link_ok),
    .frame_opcode(f_opcode),
    .frame_addr(f_addr),
    .frame_bytes(f_bytes),
    .frame_whole(f_whole)
  );

  // Link results are stable two cycles before the synced rise is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_s;
    end
  end

  assign frame_end = cs_s & ~cs_prev;
  assign accept = frame_end & device_ready & pin_s;
  assign one_byte = f_whole && f_bytes == opcode_bytes;
  assign soft_reset = accept & one_byte & armed & is_cmd(f_opcode, soft_reset_cmd);

  // Reset pin width
  always_ff @(posedge clk) begin
    if (srst || pin_s) begin
      pin_cnt <= '0;
    end else if (pin_cnt != pin_cnt_w'(reset_pulse_min_cyc)) begin
      pin_cnt <= pin_cnt + 1'b1;
    end
  end

  assign pin_hold = ~pin_s && pin_cnt == pin_cnt_w'(reset_pulse_min_cyc);
  assign reset_go = soft_reset | pin_hold;

  // Any boundary, the idle command included, drops the arming
  always_ff @(posedge clk) begin
    if (srst || reset_go) begin
      armed <= 1'b0;
    end else if (accept) begin
      armed <= one_byte & is_cmd(f_opcode, reset_arm_cmd);
    end
  end

  // Recovery keeps the longest cost seen while reset is held
  always_ff @(posedge clk) begin
    if (srst) begin
      rec_cnt <= cnt_w'(por_recovery_cyc);
    end else if (reset_go) begin
      if (recovery_cycles(running ? run_kind : held_kind) > rec_cnt) begin
        rec_cnt <= recovery_cycles(running ? run_kind : held_kind);
      end
    end else if (rec_cnt != '0) begin
      rec_cnt <= rec_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      device_ready <= 1'b0;
      link_ok <= 1'b0;
    end else begin
      device_ready <= ~reset_go & pin_s & (rec_cnt == '0);
      link_ok <= ~reset_go & pin_s & (rec_cnt == '0);
    end
  end

  // Command qualification
  assign running = run_kind != op_none;
  assign nested = running && run_kind == op_program && held_kind == op_erase;
  assign write_enable_cmd_ok = accept & one_byte & is_cmd(f_opcode, write_enable_cmd) &
                   ~program_suspended_flag;
  assign pp_ok = accept && f_whole && f_bytes > addr_frame_bytes &&
                 is_cmd(f_opcode, page_program_cmd) && write_enable_latch && !running &&
                 !program_suspended_flag &&
                 !(erase_suspended_flag && (f_addr & region_msk) == region);
  assign erase_ok = accept && f_whole && f_bytes == addr_frame_bytes &&
                    (is_cmd(f_opcode, sector_erase_cmd) || is_cmd(f_opcode, block32_erase_cmd) ||
                     is_cmd(f_opcode, block64_erase_cmd)) &&
                    write_enable_latch && !running && held_kind == op_none;
  assign susp_req = accept & one_byte &
                    (is_cmd(f_opcode, suspend_cmd_a) | is_cmd(f_opcode, suspend_cmd_b)) &
                    running & ~nested & ~suspending;
  assign resume_ok = accept & one_byte &
                     (is_cmd(f_opcode, resume_cmd_a) | is_cmd(f_opcode, resume_cmd_b)) &
                     (held_kind != op_none) & ~running & ~enhance_mode;
  assign susp_done = suspending && lat_cnt == '0;
  assign op_done = running && !suspending && run_cnt == '0;

  // Operation engine; counting freezes during suspend latency
  always_ff @(posedge clk) begin
    if (srst || reset_go) begin
      run_kind <= op_none;
      held_kind <= op_none;
      suspending <= 1'b0;
      run_cnt <= '0;
      held_cnt <= '0;
      region <= '0;
      region_msk <= '0;
    end else if (pp_ok) begin
      run_kind <= op_program;
      run_cnt <= cnt_w'(PROGRAM_CYC - 1);
    end else if (erase_ok) begin
      run_kind <= op_erase;
      run_cnt <= cnt_w'(ERASE_CYC - 1);
      region <= f_addr & erase_mask(f_opcode);
      region_msk <= erase_mask(f_opcode);
    end else if (susp_req) begin
      suspending <= 1'b1;
    end else if (susp_done) begin
      suspending <= 1'b0;
      held_kind <= run_kind;
      held_cnt <= run_cnt;
      run_kind <= op_none;
    end else if (resume_ok) begin
      run_kind <= held_kind;
      run_cnt <= held_cnt;
      held_kind <= op_none;
    end else if (op_done) begin
      run_kind <= op_none;
    end else if (running && !suspending) begin
      run_cnt <= run_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || reset_go || !suspending) begin
      lat_cnt <= cnt_w'(SUSPEND_LAT_CYC - 1);
    end else if (lat_cnt != '0) begin
      lat_cnt <= lat_cnt - 1'b1;
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (srst || reset_go) begin
      write_enable_latch <= 1'b0;
    end else if (write_enable_cmd_ok || resume_ok) begin
      write_enable_latch <= 1'b1;
    end else if (op_done || susp_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Busy flag
  always_ff @(posedge clk) begin
    if (srst || reset_go) begin
      op_in_progress_flag <= 1'b0;
    end else if (pp_ok || erase_ok || resume_ok) begin
      op_in_progress_flag <= 1'b1;
    end else if (op_done || susp_done) begin
      op_in_progress_flag <= 1'b0;
    end
  end

  // Suspend flags
  always_ff @(posedge clk) begin
    if (srst || reset_go) begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end else if (susp_done) begin
      program_suspended_flag <= run_kind == op_program;
      erase_suspended_flag <= run_kind == op_erase;
    end else if (resume_ok) begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end
  end

  // Security byte trails the flags by one cycle
  always_comb begin
    next_security = 8'h00;
    next_security[prog_susp_bit] = program_suspended_flag;
    next_security[erase_susp_bit] = erase_suspended_flag;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      security_status <= 8'h00;
      op_aborted <= 1'b0;
    end else begin
      security_status <= next_security;
      op_aborted <= reset_go & (running | held_kind != op_none);
    end
  end
endmodule

// ===== logic/level_sync.sv
// Two-flop synchroniser for a level
`timescale 1ns/10ps
module level_sync (
  // Destination clock
  input wire logic clk,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// ===== logic/param_table_link.sv
// Serial clock domain: frame capture and parameter table streaming
`timescale 1ns/10ps
module param_table_link (
  // Link clock and frame reset
  input wire logic sclk,
  input wire logic frame_rst,
  // Serial data
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Core permission, core domain level
  input wire logic table_ok,
  // Captured frame
  output logic [7:0] frame_opcode,
  output logic [23:0] frame_addr,
  output logic [3:0] frame_bytes,
  output logic frame_whole
);
  import flash_ctrl_pkg::*;

  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [6:0] shift;
  logic [3:0] tbl_idx;
  logic table_ok_s;
  logic [7:0] new_byte;
  logic [7:0] tbl_byte;

  // Arbitrary table contents apart from the signature
  function automatic logic [7:0] table_rom(input logic [3:0] idx);
    case (idx)
      4'h0: table_rom = 8'h53;
      4'h1: table_rom = 8'h46;
      4'h2: table_rom = 8'h44;
      4'h3: table_rom = 8'h50;
      4'h4: table_rom = 8'h06;
      4'h5: table_rom = 8'h01;
      4'h6: table_rom = 8'h01;
      4'h7: table_rom = 8'hff;
      4'h8: table_rom = 8'h00;
      4'h9: table_rom = 8'h06;
      4'ha: table_rom = 8'h01;
      4'hb: table_rom = 8'h10;
      4'hc: table_rom = 8'h30;
      4'hd: table_rom = 8'h00;
      4'he: table_rom = 8'h00;
      default: table_rom = 8'hff;
    endcase
  endfunction

  level_sync u_ok (
    .clk(sclk),
    .d(table_ok),
    .q(table_ok_s)
  );

  assign new_byte = {shift, si};
  assign tbl_byte = table_rom(tbl_idx);

  // Counters end with the frame, since sclk may stop after it
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == last_bit && byte_cnt != byte_cnt_max) begin
        byte_cnt <= byte_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sclk) begin
    shift <= new_byte[6:0];
  end

  // Results stay stable after the frame for the core to sample
  always_ff @(posedge sclk) begin
    if (bit_cnt == last_bit) begin
      frame_whole <= 1'b1;
      frame_bytes <= (byte_cnt == byte_cnt_max) ? byte_cnt : byte_cnt + 4'h1;
      if (byte_cnt == 4'h0) begin
        frame_opcode <= new_byte;
      end else if (byte_cnt <= last_addr_byte) begin
        frame_addr <= {frame_addr[15:0], new_byte};
      end
      if (byte_cnt == last_addr_byte) begin
        tbl_idx <= new_byte[3:0];
      end else if (byte_cnt >= table_hdr_bytes) begin
        tbl_idx <= tbl_idx + 4'h1;
      end
    end else begin
      frame_whole <= 1'b0;
      if (byte_cnt == 4'h0 && bit_cnt == 3'h0) begin
        frame_bytes <= 4'h0;
      end
    end
  end

  // Table bytes go out MSB first on the falling edge after the dummy byte
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (frame_opcode == param_table_read_cmd && byte_cnt >= table_hdr_bytes &&
                 table_ok_s) begin
      so_oe <= 1'b1;
      so <= tbl_byte[~bit_cnt];
    end else begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
  end
endmodule

// ===== verification/flash_ctrl_monitor.sv
// Port checker for the flash operation controller
`timescale 1ns/10ps
module flash_ctrl_monitor (
  // Core clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins
  input wire logic cs_n,
  input wire logic reset_pin_n,
  input wire logic enhance_mode,
  input wire logic so_oe,
  // Status
  input wire logic write_enable_latch,
  input wire logic op_in_progress_flag,
  input wire logic program_suspended_flag,
  input wire logic erase_suspended_flag,
  input wire logic [7:0] security_status,
  input wire logic device_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Two ready edges, so a reset in flight is not taken for a command
  sequence s_ready2;
    device_ready && $past(device_ready);
  endsequence
  sequence s_reset_next;
    ##1 !device_ready;
  endsequence
  property p_resume_sets;
    ($fell(erase_suspended_flag) || $fell(program_suspended_flag)) ##0 s_ready2
      |-> (write_enable_latch && op_in_progress_flag) or s_reset_next;
  endproperty
  property p_erase_susp;
    $rose(erase_suspended_flag) |-> !write_enable_latch && !op_in_progress_flag;
  endproperty
  property p_prog_susp;
    $rose(program_suspended_flag) |-> !write_enable_latch && !op_in_progress_flag;
  endproperty
  property p_sec_map;
    1'b1 |-> security_status ==
      {4'h0, $past(erase_suspended_flag), $past(program_suspended_flag), 2'h0};
  endproperty
  property p_done_clears;
    $fell(op_in_progress_flag) |-> !write_enable_latch;
  endproperty
  property p_nested_wel;
    op_in_progress_flag && erase_suspended_flag ##0 s_ready2 |-> write_enable_latch;
  endproperty
  property p_enh_blocks;
    enhance_mode && $past(enhance_mode) && erase_suspended_flag
      |=> erase_suspended_flag or s_reset_next;
  endproperty
  property p_quiet_pin;
    cs_n || !reset_pin_n |-> !so_oe;
  endproperty
  property p_busy_ignored;
    !device_ready && !$past(device_ready) |-> !$rose(write_enable_latch);
  endproperty
  a_resume_sets: assert property (p_resume_sets)
    else $error("resume did not raise latch and busy");
  a_erase_susp: assert property (p_erase_susp)
    else $error("erase suspend left latch or busy set");
  a_prog_susp: assert property (p_prog_susp)
    else $error("program suspend left latch or busy set");
  a_sec_map: assert property (p_sec_map)
    else $error("security status bits misplaced");
  a_done_clears: assert property (p_done_clears)
    else $error("latch still set after operation end");
  a_nested_wel: assert property (p_nested_wel)
    else $error("latch low during program in erase suspend");
  a_enh_blocks: assert property (p_enh_blocks)
    else $error("resume taken in enhanced mode");
  a_quiet_pin: assert property (p_quiet_pin)
    else $error("output driven while deselected or in reset");
  a_busy_ignored: assert property (p_busy_ignored)
    else $error("command taken while not ready");
endmodule

// ===== verification/flash_host_model.sv
// Host serial controller model that frames commands for the flash
`timescale 1ns/10ps
module flash_host_model (
  // Link pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic si,
  // Data back from the device
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Mode 0, MSB first; clock stands low between frames
  task automatic frame(input logic [39:0] tx, input int nb, input int nrd,
    output logic [31:0] rx, output logic oe_seen);
    int i;
    rx = 32'h0;
    oe_seen = 1'b1;
    cs_n = 1'b0;
    for (i = 0; i < (nb + nrd) * 8; i++) begin
      si = (i < nb * 8) ? tx[39 - i] : ~si;
      #7.5 sclk = 1'b1;
      if (i >= nb * 8) begin
        rx = {rx[30:0], so};
        oe_seen = oe_seen & so_oe;
      end
      #7.5 sclk = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    si = ~si;
    // Gap so the core sees every rise of select
    #100;
  endtask
endmodule

// ===== verification/flash_suspend_resume_reset_ctrl_tb.sv
// Self-checking bench for the flash operation controller
`timescale 1ns/10ps
module flash_suspend_resume_reset_ctrl_tb;
  import flash_ctrl_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic enhance_mode = 1'b0;
  logic sclk, cs_n, si, so, so_oe, write_enable_latch, op_in_progress_flag;
  logic program_suspended_flag, erase_suspended_flag, device_ready, op_aborted;
  logic [7:0] security_status;
  logic [31:0] seed = 32'h13;
  logic [31:0] r, rx;
  logic oe_seen;
  logic aborted_seen = 1'b0;
  logic ready_q = 1'b0;
  int lo_cnt = 0;
  int lo_len = 0;
  int err_total = 0;
  int n_checks = 0;
  // Arbitrary bench value for the host's wait after a resume
  localparam int erase_resume_to_suspend_gap = 20;
  always #5 clk = ~clk;
  // Length of the last not-ready stretch
  always @(posedge clk) begin
    ready_q <= device_ready;
    lo_cnt <= (device_ready === 1'b1) ? 0 : lo_cnt + 1;
    if (device_ready === 1'b1 && !ready_q) lo_len <= lo_cnt;
    if (op_aborted === 1'b1) aborted_seen <= 1'b1;
  end
  flash_suspend_resume_reset_ctrl #(.PROGRAM_CYC(300), .ERASE_CYC(600), .SUSPEND_LAT_CYC(40),
    .RECOVER_PROGRAM_CYC(50), .RECOVER_ERASE_CYC(80)) flash_suspend_resume_reset_ctrl_inst (
    .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .reset_pin_n(reset_pin_n), .enhance_mode(enhance_mode),
    .write_enable_latch(write_enable_latch), .op_in_progress_flag(op_in_progress_flag),
    .program_suspended_flag(program_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag), .security_status(security_status),
    .device_ready(device_ready), .op_aborted(op_aborted));
  flash_host_model flash_host_model_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] st();
    return {write_enable_latch, op_in_progress_flag, program_suspended_flag,
      erase_suspended_flag};
  endfunction
  function automatic logic [7:0] sec_exp(input logic p, input logic e);
    logic [7:0] v;
    v = 8'h0;
    v[prog_susp_bit] = p;
    v[erase_susp_bit] = e;
    return v;
  endfunction
  task automatic cmd(input logic [39:0] tx, input int nb);
    @(posedge clk);
    #1;
    flash_host_model_inst.frame(tx, nb, 0, rx, oe_seen);
  endtask
  task automatic op1(input logic [7:0] c);
    cmd({c, 32'h0}, 1);
  endtask
  task automatic prog(input logic [23:0] a);
    op1(write_enable_cmd);
    r = rnd();
    cmd({page_program_cmd, a, r[7:0]}, 5);
  endtask
  task automatic wait_for(input logic want_ready, input int lim);
    int n;
    n = 0;
    while ((want_ready ? device_ready : !op_in_progress_flag) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wait", 1, n < lim);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    #600000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    op1(write_enable_cmd);
    chk("status", 4'h0, st());
    chk("ready", 0, device_ready);
    wait_for(1, 4000);
    op1(write_enable_cmd);
    chk("status", 4'h8, st());
    cmd({sector_erase_cmd, 24'h001000, 8'h0}, 4);
    chk("status", 4'hc, st());
    op1(suspend_cmd_b);
    chk("status", 4'hc, st());
    settle(40);
    chk("status", 4'h1, st());
    chk("security", sec_exp(0, 1), security_status);
    r = rnd();
    prog({12'h001, r[11:0]});
    chk("status", 4'h9, st());
    r = rnd();
    prog({8'h01, r[15:0]});
    chk("status", 4'hd, st());
    op1(resume_cmd_a);
    chk("status", 4'hd, st());
    op1(suspend_cmd_a);
    settle(50);
    chk("status", 4'hd, st());
    wait_for(0, 400);
    chk("status", 4'h1, st());
    @(posedge clk);
    enhance_mode <= 1'b1;
    op1(resume_cmd_b);
    chk("status", 4'h1, st());
    @(posedge clk);
    enhance_mode <= 1'b0;
    op1(resume_cmd_a);
    chk("status", 4'hc, st());
    settle(erase_resume_to_suspend_gap);
    op1(suspend_cmd_b);
    settle(45);
    chk("status", 4'h1, st());
    op1(resume_cmd_a);
    chk("status", 4'hc, st());
    wait_for(0, 700);
    chk("status", 4'h0, st());
    r = rnd();
    prog({8'h02, r[15:0]});
    op1(suspend_cmd_a);
    settle(40);
    chk("status", 4'h2, st());
    chk("security", sec_exp(1, 0), security_status);
    op1(resume_cmd_b);
    chk("status", 4'hc, st());
    wait_for(0, 400);
    chk("status", 4'h0, st());
    op1(reset_arm_cmd);
    op1(idle_cmd);
    op1(soft_reset_cmd);
    chk("ready", 1, device_ready);
    op1(reset_arm_cmd);
    op1(write_enable_cmd);
    op1(soft_reset_cmd);
    chk("status", 4'h8, st());
    r = rnd();
    prog({8'h03, r[15:0]});
    op1(reset_arm_cmd);
    op1(soft_reset_cmd);
    chk("status", 4'h0, st());
    chk("aborted", 1, aborted_seen);
    wait_for(1, 200);
    // Stretch length lands one edge after ready is seen
    settle(1);
    chk("recovery", 1, lo_len >= 50 && lo_len <= 54);
    op1(write_enable_cmd);
    op1(reset_arm_cmd);
    op1(soft_reset_cmd);
    chk("status", 4'h0, st());
    op1(write_enable_cmd);
    chk("status", 4'h0, st());
    wait_for(1, 3200);
    settle(1);
    chk("recovery", 1, lo_len >= 3000 && lo_len <= 3004);
    @(posedge clk);
    #1;
    flash_host_model_inst.frame({param_table_read_cmd, 32'h0}, 5, 4, rx, oe_seen);
    // Signature spelled by the first four table bytes
    chk("table", 32'h53464450, rx);
    chk("oe", 1, oe_seen);
    chk("oe", 0, so_oe);
    op1(write_enable_cmd);
    r = rnd();
    cmd({block32_erase_cmd, r[23:0], 8'h0}, 4);
    chk("status", 4'hc, st());
    @(posedge clk);
    reset_pin_n <= 1'b0;
    settle(1100);
    chk("status", 4'h0, st());
    chk("oe", 0, so_oe);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    // Held reset takes the longest cost seen, the decode one included
    wait_for(1, 3200);
    settle(1000);
    op1(write_enable_cmd);
    chk("status", 4'h8, st());
    @(posedge clk);
    reset_pin_n <= 1'b0;
    settle(20);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    wait_for(1, 4000);
    chk("status", 4'h8, st());
    test_done();
  end
endmodule
bind flash_suspend_resume_reset_ctrl flash_ctrl_monitor flash_ctrl_monitor_inst (
  .clk, .srst, .cs_n, .reset_pin_n, .enhance_mode, .so_oe, .write_enable_latch,
  .op_in_progress_flag, .program_suspended_flag, .erase_suspended_flag, .security_status,
  .device_ready);
